/* File: lbw_blinker.sv */
// Single-wire configuration receiver and two-pulse blink sequencer.
// Assumes line_in is an asynchronous pin driven by a host that bit-bangs.
`timescale 1ns/1ps
`default_nettype none

module lbw_blinker
    import lbw_pkg::*;
#(
    parameter logic [13:0] HOLD_LEN = 14'(HOLD_CYC),
    parameter logic [23:0] ON_UNIT = 24'(ON_UNIT_CYC),
    parameter logic [23:0] OFF_UNIT = 24'(OFF_UNIT_CYC),
    parameter logic [23:0] STEP_UNIT = 24'(STEP_UNIT_CYC),
    parameter logic [23:0] MIN_TIME = 24'(MIN_TIME_CYC)
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic line_in,
    output logic [4:0] led_level,
    output logic pattern_run,
    output logic [1:0] current_range
);

    lbw_state_t s_r;
    lbw_state_t s_nxt;

    // ======================================================
    // Line edge and phase measurement
    logic rise;
    logic fall;
    logic hold;
    logic bit_val;
    logic [10:0] word;
    logic [7:0] cfg;

    assign rise = s_r.sync2 & ~s_r.prev;
    assign fall = ~s_r.sync2 & s_r.prev;
    assign hold = ~(rise | fall) && (s_r.ph_cnt == HOLD_LEN - 14'h1);
    // The low phase is the running count when the next rising edge arrives.
    assign bit_val = s_r.hi_len > s_r.ph_cnt;
    assign word = {bit_val, s_r.sr[10:1]};
    assign cfg = s_r.regs[ADDR_CFG];

    // ======================================================
    // Pulse timing selection
    logic [7:0] ramp_reg;
    logic [7:0] cnt_reg;
    logic slow;
    logic sec_en;
    logic [23:0] unit_len;
    logic [4:0] target;
    logic tick;
    logic done;
    logic keep_going;

    assign ramp_reg = s_r.pulse ? s_r.regs[ADDR_RAMP2] : s_r.regs[ADDR_RAMP1];
    assign cnt_reg = s_r.pulse ? s_r.regs[ADDR_ON_OFF_COUNTS_SECOND] : s_r.regs[ADDR_ON_OFF_COUNTS_FIRST];
    assign slow = cfg[CFG_SLOW];
    assign sec_en = (s_r.regs[ADDR_ON_OFF_COUNTS_SECOND][7:4] != 4'h0)
        && (s_r.regs[ADDR_ON_OFF_COUNTS_SECOND][3:0] != 4'h0);
    assign keep_going = cfg[CFG_REPEAT] | (cfg[CFG_TRACK] & s_r.sync2);

    always_comb begin
        unit_len = STEP_UNIT;
        target = 5'h00;
        unique case (s_r.pst)
            PT_RISE: target = {1'b0, ramp_reg[7:4]};
            PT_FALL: target = {1'b0, ramp_reg[3:0]};
            PT_ON: begin
                if (cnt_reg[7:4] == 4'h0) begin
                    // Pulse two never runs with a zero count, so only
                    // pulse one lands here and gets the short floor.
                    unit_len = MIN_TIME;
                    target = s_r.pulse ? 5'h00 : 5'h01;
                end else begin
                    unit_len = ON_UNIT;
                    target = slow ? {cnt_reg[7:4], 1'b0}
                                  : {1'b0, cnt_reg[7:4]};
                end
            end
            PT_OFF: begin
                if (cnt_reg[3:0] == 4'h0) begin
                    unit_len = MIN_TIME;
                    target = s_r.pulse ? 5'h00 : 5'h01;
                end else begin
                    unit_len = OFF_UNIT;
                    target = slow ? {cnt_reg[3:0], 1'b0}
                                  : {1'b0, cnt_reg[3:0]};
                end
            end
            default: begin
                unit_len = STEP_UNIT;
                target = 5'h00;
            end
        endcase
    end

    assign tick = s_r.cyc == unit_len - 24'h1;
    assign done = (target == 5'h00)
        || (tick && (s_r.units == target - 5'h01));

    // ======================================================
    // Next state
    always_comb begin
        s_nxt = s_r;
        s_nxt.sync1 = line_in;
        s_nxt.sync2 = s_r.sync1;
        s_nxt.prev = s_r.sync2;
        if (rise || fall) begin
            s_nxt.ph_cnt = 14'h0000;
        end else if (s_r.ph_cnt != 14'h3FFF) begin
            s_nxt.ph_cnt = s_r.ph_cnt + 14'h0001;
        end
        if (fall) begin
            s_nxt.hi_len = s_r.ph_cnt;
        end

        // Receiver.
        unique case (s_r.rx)
            RX_IDLE, RX_GAP: begin
                if (rise) begin
                    // Any rising edge after the stop bit opens a word.
                    s_nxt.rx = RX_WORD;
                    s_nxt.bits = 4'h0;
                end else if (hold && !s_r.sync2) begin
                    s_nxt.rx = RX_IDLE;
                end
            end
            RX_WORD: begin
                if (rise) begin
                    s_nxt.sr = word;
                    s_nxt.bits = s_r.bits + 4'h1;
                    if (s_r.bits == WORD_LAST) begin
                        // Address in bits 2:0, data in bits 10:3.
                        if (word[2:0] <= ADDR_CFG) begin
                            s_nxt.regs[word[2:0]] = word[10:3];
                        end
                        s_nxt.rx = RX_STOP;
                    end
                end else if (s_r.ph_cnt > PHASE_MAX_CYC) begin
                    // Partial bits are simply dropped; nothing was written.
                    s_nxt.rx = RX_IDLE;
                end
            end
            RX_STOP: begin
                if (fall) begin
                    s_nxt.rx = RX_GAP;
                end
            end
        endcase

        // Pattern sequencer.
        if (s_r.pst != PT_IDLE) begin
            if (done || tick) begin
                s_nxt.cyc = 24'h000000;
                s_nxt.units = s_r.units + 5'h01;
            end else begin
                s_nxt.cyc = s_r.cyc + 24'h000001;
            end
            if (done) begin
                s_nxt.units = 5'h00;
            end
        end
        unique case (s_r.pst)
            PT_IDLE: begin
                s_nxt.level = 5'h00;
            end
            PT_RISE: begin
                if (target == 5'h00) begin
                    s_nxt.level = LEVEL_FULL;
                    s_nxt.pst = PT_ON;
                end else if (done) begin
                    s_nxt.level = s_r.level + 5'h01;
                    if (s_r.level == LEVEL_FULL - 5'h01) begin
                        s_nxt.pst = PT_ON;
                    end
                end
            end
            PT_ON: begin
                if (done) begin
                    s_nxt.pst = PT_FALL;
                end
            end
            PT_FALL: begin
                if (target == 5'h00) begin
                    s_nxt.level = 5'h00;
                    s_nxt.pst = PT_OFF;
                end else if (done) begin
                    s_nxt.level = s_r.level - 5'h01;
                    if (s_r.level == 5'h01) begin
                        s_nxt.pst = PT_OFF;
                    end
                end
            end
            PT_OFF: begin
                if (done) begin
                    if (!s_r.pulse && sec_en) begin
                        s_nxt.pulse = 1'b1;
                        s_nxt.pst = PT_RISE;
                    end else begin
                        s_nxt.pulse = 1'b0;
                        s_nxt.pst = keep_going ? PT_RISE : PT_IDLE;
                        s_nxt.run = keep_going;
                    end
                end
            end
            default: begin
                s_nxt.pst = PT_IDLE;
                s_nxt.run = 1'b0;
            end
        endcase

        // A long high starts a fresh pattern; a long low halts one
        // unless the repeat bit lets it run on by itself.
        if (hold && s_r.sync2 && s_r.pst == PT_IDLE) begin
            s_nxt.pst = PT_RISE;
            s_nxt.run = 1'b1;
            s_nxt.pulse = 1'b0;
            s_nxt.level = 5'h00;
            s_nxt.cyc = 24'h000000;
            s_nxt.units = 5'h00;
        end else if (hold && !s_r.sync2 && !cfg[CFG_REPEAT]) begin
            s_nxt.pst = PT_IDLE;
            s_nxt.run = 1'b0;
            s_nxt.level = 5'h00;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
            s_r.regs <= {RST_CFG, RST_ON_OFF_COUNTS_SECOND, RST_RAMP2, RST_ON_OFF_COUNTS_FIRST,
                         RST_RAMP1};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign led_level = s_r.level;
    assign pattern_run = s_r.run;
    assign current_range = cfg[CFG_RANGE_HI:CFG_RANGE_LO];

    // ======================================================
    // Checks
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    sequence last_bit_edge;
        s_r.rx == RX_WORD && rise && s_r.bits == WORD_LAST;
    endsequence

    a_stop_write: assert property (
        last_bit_edge and (word[2:0] == ADDR_CFG)
        |=> s_r.regs[ADDR_CFG] == $past(word[10:3]) && s_r.rx == RX_STOP)
        else $error("config not loaded at stop edge");

    a_abort_keeps: assert property (
        s_r.rx == RX_WORD && !rise && s_r.ph_cnt > PHASE_MAX_CYC
        |=> s_r.rx == RX_IDLE && $stable(s_r.regs))
        else $error("overlong phase did not abort word");

    a_bit_decode: assert property (
        s_r.rx == RX_WORD && rise
        |=> s_r.sr[10] == ($past(s_r.hi_len) > $past(s_r.ph_cnt)))
        else $error("bit decoded against duty ratio");

    a_no_mid_write: assert property (
        s_r.rx != RX_WORD || !rise || s_r.bits != WORD_LAST
        |=> $stable(s_r.regs))
        else $error("registers changed outside stop edge");

    a_ramp_full: assert property (
        s_r.pst == PT_RISE ##1 s_r.pst == PT_ON |-> s_r.level == LEVEL_FULL)
        else $error("rise ended below full level");

    a_zero_jump: assert property (
        s_r.pst == PT_RISE && target == 5'h00
        |=> s_r.level == LEVEL_FULL && s_r.pst == PT_ON)
        else $error("zero rise count still ramped");

    a_skip_second: assert property (
        s_r.pst == PT_OFF && done && !sec_en |=> !s_r.pulse)
        else $error("second pulse ran while disabled");

    a_hold_start: assert property (
        hold && s_r.sync2 && s_r.pst == PT_IDLE
        |=> s_r.run && s_r.pst == PT_RISE && s_r.level == 5'h00)
        else $error("long high did not start pattern");

    // The first pulse may not leave its on state before the floor has run.
    a_first_min: assert property (
        s_r.pst == PT_ON && !s_r.pulse && !hold && s_r.units == 5'h00
        && s_r.cyc < MIN_TIME - 24'h1 |=> s_r.pst == PT_ON)
        else $error("first pulse on time below floor");

    a_low_idle: assert property (
        s_r.rx == RX_GAP && hold && !s_r.sync2 |=> s_r.rx == RX_IDLE)
        else $error("long low did not return to idle");

endmodule : lbw_blinker

`default_nettype wire

/* File: lbw_pkg.sv */
// Constants and types for the single-wire blink controller.
// Assumes one 50 MHz clock; all times are converted to cycle counts here.
//
// Operation
// - On time is (slow+1) x count x 106.6 ms
// - Off time is (slow+1) x count x 320 ms
// - Two pulses, each with own timing
// - Maxima 1600/4800 ms, doubled when slow
// - Zero on-count holds on for the 6.7 ms floor, then ramps down
// - Second pulse skipped if either count zero
// - First pulse on/off at least 6.7 ms
// - Upper nibble on/rise, lower off/fall
// - Config: range 7:6, slow 2, repeat 1, track 0
// - Interrupted word is discarded, registers unchanged
// - Word sent least significant bit first
// - Bit is 1 when high outlasts low
// - Data loads at stop bit rising edge
// - New word accepted on the first rise after stop falls
// - Low 200 us after stop returns idle
// - High 200 us starts the pattern
// - Word: 3 address bits, 8 data bits
// - Repeat and track bits select line response
// - Ramp is 31 steps of count x 3.33 ms
// - Zero step count switches without ramp
package lbw_pkg;

    // ======================================================
    // Register map and fields
    localparam logic [2:0] ADDR_RAMP1 = 3'h0;
    localparam logic [2:0] ADDR_ON_OFF_COUNTS_FIRST = 3'h1;
    localparam logic [2:0] ADDR_RAMP2 = 3'h2;
    localparam logic [2:0] ADDR_ON_OFF_COUNTS_SECOND = 3'h3;
    localparam logic [2:0] ADDR_CFG = 3'h4;
    localparam logic [7:0] RST_RAMP1 = 8'h55;
    localparam logic [7:0] RST_ON_OFF_COUNTS_FIRST = 8'h55;
    localparam logic [7:0] RST_RAMP2 = 8'h55;
    localparam logic [7:0] RST_ON_OFF_COUNTS_SECOND = 8'h00;
    localparam logic [7:0] RST_CFG = 8'h00;
    localparam int CFG_RANGE_HI = 7;
    localparam int CFG_RANGE_LO = 6;
    localparam int CFG_SLOW = 2;
    localparam int CFG_REPEAT = 1;
    localparam int CFG_TRACK = 0;
    localparam logic [3:0] WORD_LAST = 4'hA;
    localparam logic [4:0] LEVEL_FULL = 5'h1F;

    // ======================================================
    // Timing
    localparam int CLK_NS = 20;
    localparam int PHASE_MAX_NS = 40000;
    localparam int HOLD_NS = 200000;
    localparam int ON_UNIT_NS = 106600000;
    localparam int OFF_UNIT_NS = 320000000;
    localparam int STEP_UNIT_NS = 3330000;
    localparam int MIN_TIME_NS = 6700000;
    localparam logic [13:0] PHASE_MAX_CYC = 14'(PHASE_MAX_NS / CLK_NS);
    localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int ON_UNIT_CYC = ON_UNIT_NS / CLK_NS;
    localparam int OFF_UNIT_CYC = OFF_UNIT_NS / CLK_NS;
    localparam int STEP_UNIT_CYC = STEP_UNIT_NS / CLK_NS;
    localparam int MIN_TIME_CYC = (MIN_TIME_NS + CLK_NS - 1) / CLK_NS;

    // ======================================================
    // Types
    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_WORD = 2'b01,
        RX_STOP = 2'b10,
        RX_GAP = 2'b11
    } lbw_rx_t;

    typedef enum logic [2:0] {
        PT_IDLE = 3'b000,
        PT_RISE = 3'b001,
        PT_ON = 3'b010,
        PT_FALL = 3'b011,
        PT_OFF = 3'b100
    } lbw_pat_t;

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic prev;
        logic [13:0] ph_cnt;
        logic [13:0] hi_len;
        lbw_rx_t rx;
        logic [3:0] bits;
        logic [10:0] sr;
        logic [4:0][7:0] regs;
        lbw_pat_t pst;
        logic pulse;
        logic run;
        logic [23:0] cyc;
        logic [4:0] units;
        logic [4:0] level;
    } lbw_state_t;

endpackage : lbw_pkg

/* File: lbw_host_model.sv */
// Host model for the single-wire link: bit-bangs write words on the line.
// Assumes the 50 MHz bench clock; every phase length is a cycle count.
`timescale 1ns/1ps
`default_nettype none

module lbw_host_model
    import lbw_pkg::*;
#(
    parameter int SHORT_CYC = 25,
    parameter int LONG_CYC = 75
) (
    input wire logic ref_clk,
    output logic line_out
);
    // ====================
    // Line driving
    initial begin
        line_out = 1'b0;
    end

    // Moves only just after a clock edge, like a software loop would.
    task automatic line_level(input logic v, input int n);
        line_out = v;
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : line_level

    // Fewer than 11 bits leaves a broken word behind on the line.
    task automatic send_word(input logic [2:0] a, input logic [7:0] d,
                             input int nbits);
        logic [10:0] word;
        word = {d, a};
        for (int i = 0; i < nbits; i++) begin
            line_level(1'b1, word[i] ? LONG_CYC : SHORT_CYC);
            line_level(1'b0, word[i] ? SHORT_CYC : LONG_CYC);
        end
        if (nbits == 11) begin
            line_level(1'b1, SHORT_CYC);
        end
    endtask : send_word

endmodule : lbw_host_model

`default_nettype wire

/* File: tb.sv */
// Self-checking bench for the single-wire blink controller.
// Assumes the host model drives the line and shortened time units.
`timescale 1ns/1ps
`default_nettype none

module tb;
    import lbw_pkg::*;
    localparam int HOLD_P = 200;
    localparam int ON_P = 40;
    localparam int OFF_P = 60;
    localparam int STEP_P = 4;
    localparam int MIN_P = 8;
    typedef struct packed {
        logic [7:0] r1;
        logic [7:0] p1;
        logic [7:0] p2;
        logic [7:0] cfg;
    } lbw_row_t;
    typedef struct packed {
        logic [2:0] a;
        logic [7:0] d;
        logic [3:0] n;
        logic [1:0] rng;
    } lbw_word_t;
    logic ref_clk;
    logic rst_n;
    logic line_in;
    logic [4:0] led_level;
    logic pattern_run;
    logic [1:0] current_range;
    int err_total;
    int n_tests;
    lbw_row_t rows [6];
    lbw_word_t words [7];

    // Hold interval kept above the longest bit phase of the host.
    lbw_blinker #(.HOLD_LEN(14'(HOLD_P)), .ON_UNIT(24'(ON_P)),
        .OFF_UNIT(24'(OFF_P)), .STEP_UNIT(24'(STEP_P)),
        .MIN_TIME(24'(MIN_P))) i_dut (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .line_in(line_in),
        .led_level(led_level),
        .pattern_run(pattern_run),
        .current_range(current_range)
    );
    lbw_host_model i_host (.ref_clk(ref_clk), .line_out(line_in));

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    // ====================
    // Helpers
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : step

    task automatic check(input logic [31:0] s, input logic [31:0] e,
                         input int t);
        n_tests++;
        if ((t == 0) ? (s !== e)
                     : ($isunknown(s) || s + t < e || s > e + t)) begin
            $display("[ERR] t=%0t seen=0x%0h exp=0x%0h", $time, s, e);
            err_total++;
        end
    endtask : check

    task automatic end_of_test();
        $display("Checks %0d, errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_of_test

    task automatic wait_sig(input logic run, input logic [4:0] v,
                            output int k);
        k = 0;
        while ((run ? pattern_run !== 1'b1 : led_level !== v) && k < 2000)
        begin
            step(1);
            k++;
        end
        if (k == 2000) begin
            err_total++;
            end_of_test();
        end
    endtask : wait_sig

    task automatic run_len(input logic [4:0] v, output int len);
        int k;
        wait_sig(1'b0, v, k);
        len = 0;
        while (led_level === v && pattern_run === 1'b1 && len < 4000) begin
            step(1);
            len++;
        end
    endtask : run_len

    task automatic do_reset();
        rst_n = 1'b0;
        i_host.line_level(1'b0, 5);
        check(32'(led_level), 32'h0, 0);
        check(32'(pattern_run), 32'h0, 0);
        check(32'(current_range), 32'h0, 0);
        rst_n = 1'b1;
        step(3);
    endtask : do_reset

    task automatic put(input logic [2:0] a, input logic [7:0] d);
        i_host.send_word(a, d, 11);
        i_host.line_level(1'b0, 210);
    endtask : put

    function automatic int t_on(logic [3:0] n, logic [7:0] c);
        return (n == 0) ? MIN_P : (int'(c[CFG_SLOW]) + 1) * n * ON_P;
    endfunction : t_on

    function automatic int t_off(logic [3:0] n, logic [7:0] c);
        return (n == 0) ? MIN_P : (int'(c[CFG_SLOW]) + 1) * n * OFF_P;
    endfunction : t_off

    // ====================
    // Main sequence
    initial begin
        int ln;
        int k;
        logic [7:0] c;
        logic [7:0] p;
        rst_n = 1'b0;
        err_total = 0;
        n_tests = 0;
        rows = '{'{8'h00, 8'h21, 8'h00, 8'h40}, '{8'h00, 8'h21, 8'h00, 8'h84},
            '{8'h00, 8'h21, 8'h13, 8'hC0}, '{8'h00, 8'h00, 8'h10, 8'h00},
            '{8'h00, 8'h21, 8'h00, 8'h01}, '{8'h00, 8'h32, 8'h13, 8'h06}};
        words = '{'{ADDR_CFG, 8'hC0, 4'hB, 2'h3}, '{3'h5, 8'h40, 4'hB, 2'h3},
            '{ADDR_RAMP1, 8'h80, 4'hB, 2'h3}, '{ADDR_CFG, 8'h40, 4'h7, 2'h3},
            '{ADDR_CFG, 8'h02, 4'hB, 2'h0}, '{ADDR_CFG, 8'h40, 4'hB, 2'h1},
            '{ADDR_CFG, 8'h80, 4'hB, 2'h2}};
        step(1);
        foreach (rows[i]) begin
            c = rows[i].cfg;
            p = rows[i].p2;
            do_reset();
            put(ADDR_RAMP1, rows[i].r1);
            put(ADDR_ON_OFF_COUNTS_FIRST, rows[i].p1);
            put(ADDR_RAMP2, 8'h00);
            put(ADDR_ON_OFF_COUNTS_SECOND, p);
            i_host.send_word(ADDR_CFG, c, 11);
            check(32'(current_range), 32'(c[7:6]), 0);
            i_host.line_level(1'b0, 210);
            i_host.line_level(1'b1, 0);
            wait_sig(1'b1, 5'h00, k);
            check(k, HOLD_P, 6);
            run_len(5'h1F, ln);
            check(ln, t_on(rows[i].p1[7:4], c), 3);
            run_len(5'h00, ln);
            check(ln, t_off(rows[i].p1[3:0], c), 3);
            if (p[7:4] != 0 && p[3:0] != 0) begin
                run_len(5'h1F, ln);
                check(ln, t_on(p[7:4], c), 3);
                run_len(5'h00, ln);
                check(ln, t_off(p[3:0], c), 3);
            end else if (c[1:0] != 0) begin
                run_len(5'h1F, ln);
                check(ln, t_on(rows[i].p1[7:4], c), 3);
            end
            check(32'(pattern_run), 32'(c[1] | c[0]), 0);
        end
        // Awkward words: foreign address, broken word, each range value.
        do_reset();
        foreach (words[i]) begin
            i_host.send_word(words[i].a, words[i].d, int'(words[i].n));
            if (words[i].n == 4'hB) begin
                check(32'(current_range), 32'(words[i].rng), 0);
                i_host.line_level(1'b0, 210);
            end else begin
                i_host.line_level(1'b0, 2100);
                check(32'(current_range), 32'(words[i].rng), 0);
            end
        end
        // Ramp up in single steps, then a reset in mid-pattern.
        do_reset();
        put(ADDR_RAMP1, 8'h10);
        put(ADDR_ON_OFF_COUNTS_FIRST, 8'h21);
        i_host.line_level(1'b1, 0);
        wait_sig(1'b1, 5'h00, k);
        wait_sig(1'b0, 5'h1F, k);
        check(k, 31 * STEP_P, 6);
        run_len(5'h1F, ln);
        check(ln, 2 * ON_P, 3);
        do_reset();
        // A long low halts a pattern that is not set to repeat.
        i_host.line_level(1'b1, 0);
        wait_sig(1'b1, 5'h00, k);
        i_host.line_level(1'b0, 210);
        check(32'(pattern_run), 32'h0, 0);
        check(32'(led_level), 32'h0, 0);
        end_of_test();
    end

endmodule : tb

`default_nettype wire
